// ### src/fseq_core.sv
// core end: AHB-Lite slave turning software orders into link strobes
// assumes one AHB master on hclk; the sequencer end shares hclk
`timescale 1ns/1ps
`include "fseq_defines.svh"
module fseq_core (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  fseq_if.core link
);
  import fseq_pkg::*;
  logic accept;
  logic dp_wr_r;
  logic dp_map_r;
  logic [3:0] dp_off_r;
  logic [31:0] hrdata_r;
  logic fc_we_r;
  fseq_byte_t fc_wdata_r;
  logic xd_we_r;
  fseq_addr_t xd_addr_r;
  fseq_byte_t xd_wdata_r;
  logic cr_re_r;
  fseq_addr_t cr_addr_r;
  fseq_byte_t code_r;
  logic pend_r;
  logic dp_hit;

  assign accept = hsel && hready && htrans[1];
  assign dp_hit = dp_wr_r && dp_map_r;

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_r <= 1'b0;
      dp_map_r <= 1'b0;
      dp_off_r <= 4'h0;
    end else if (hready) begin
      dp_wr_r <= accept && hwrite;
      dp_map_r <= (haddr[31:4] == 28'h0) && (hsize == 3'h2);
      dp_off_r <= haddr[3:0];
    end
  end

  // read data prepared for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0;
    end else if (accept && !hwrite && haddr[31:4] == 28'h0) begin
      case (haddr[3:0])
        `FSEQ_H_CTRL: hrdata_r <= {24'h0, link.fc_rdata};
        `FSEQ_H_STAT: hrdata_r <= {14'h0, pend_r, link.core_hold,
                                   link.fc_rdata, code_r};
        default: hrdata_r <= 32'h0;
      endcase
    end else if (accept) begin
      hrdata_r <= 32'h0;
    end
  end

  // link strobes, one cycle each, after the write data phase [R6] [R3]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fc_we_r <= 1'b0;
      fc_wdata_r <= 8'h0;
      xd_we_r <= 1'b0;
      xd_addr_r <= 16'h0;
      xd_wdata_r <= 8'h0;
      cr_re_r <= 1'b0;
      cr_addr_r <= 16'h0;
    end else begin
      fc_we_r <= dp_hit && dp_off_r == `FSEQ_H_CTRL;
      xd_we_r <= dp_hit && dp_off_r == `FSEQ_H_LOAD;
      cr_re_r <= dp_hit && dp_off_r == `FSEQ_H_READ;
      if (dp_hit && dp_off_r == `FSEQ_H_CTRL) begin
        fc_wdata_r <= hwdata[7:0];
      end
      if (dp_hit && dp_off_r == `FSEQ_H_LOAD) begin
        xd_addr_r <= hwdata[15:0];
        xd_wdata_r <= hwdata[`FSEQ_LD_DATA_LO+7:`FSEQ_LD_DATA_LO];
      end
      if (dp_hit && dp_off_r == `FSEQ_H_READ) begin
        cr_addr_r <= hwdata[15:0];
      end
    end
  end

  // code read result and pending flag; a new issue wins over the answer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      code_r <= 8'h0;
      pend_r <= 1'b0;
    end else begin
      if (link.cr_valid) begin
        code_r <= link.cr_rdata;
      end
      if (cr_re_r) begin
        pend_r <= 1'b1;
      end else if (link.cr_valid || !link.core_hold) begin
        pend_r <= pend_r && !link.cr_valid && link.core_hold;
      end
    end
  end

  // zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign hrdata = hrdata_r;
  assign link.fc_we = fc_we_r;
  assign link.fc_wdata = fc_wdata_r;
  assign link.xd_we = xd_we_r;
  assign link.xd_addr = xd_addr_r;
  assign link.xd_wdata = xd_wdata_r;
  assign link.cr_re = cr_re_r;
  assign link.cr_addr = cr_addr_r;
endmodule

// ### src/fseq_defines.svh
// constants for the flash program sequencer: offsets, fields, timing
// assumes inclusion by bare name from every file that needs them
`ifndef FSEQ_DEFINES_SVH
`define FSEQ_DEFINES_SVH
`define FSEQ_FC_OFFSET 8'hd1
`define FSEQ_FC_RESET 8'h00
`define FSEQ_KEY_HI 7
`define FSEQ_KEY_LO 4
`define FSEQ_MAP_BIT 3
`define FSEQ_SPACE_HI 2
`define FSEQ_SPACE_LO 1
`define FSEQ_BUSY_BIT 0
`define FSEQ_KEY_ARM 4'h5
`define FSEQ_KEY_GO 4'ha
`define FSEQ_SP_USER 2'h0
`define FSEQ_SP_XROW 2'h1
`define FSEQ_SP_SEC 2'h2
`define FSEQ_SP_RSVD 2'h3
`define FSEQ_PAGE_BYTES 128
`define FSEQ_PAGES 256
`define FSEQ_XROW_BASE 16'hff80
`define FSEQ_SEC_ADDR 16'h0000
`define FSEQ_ERASED 8'hff
`define FSEQ_SEC_DEFAULT 8'hff
`define FSEQ_CLK_NS 4
`define FSEQ_PROG_TIME_NS 10000000
`define FSEQ_PROG_CYCLES (`FSEQ_PROG_TIME_NS / `FSEQ_CLK_NS)
`define FSEQ_H_CTRL 4'h0
`define FSEQ_H_LOAD 4'h4
`define FSEQ_H_READ 4'h8
`define FSEQ_H_STAT 4'hc
`define FSEQ_LD_DATA_LO 16
`endif

// ### src/fseq_device.sv
// flash sequencer end: control register, column latches, flash arrays
// assumes the core end drives one-cycle strobes on hclk
// Operation
// [R1] latches take one to 128 bytes
// [R2] erase then program only loaded locations
// [R3] software maps latches, then writes bytes
// [R4] user data loaded at 0000h to 7FFFh
// [R5] page comes from last latch load
// [R6] user launch is 50h then A0h
// [R7] extra row loaded high, launched 52h/A2h
// [R8] security byte via 0x0C, then 54h/A4h
// [R9] write 00h, code reads user array
// [R10] write 02h, code reads extra row
// [R11] write 04h, code reads security byte
// [R12] key 5 then A launches programming
// [R13] map bit redirects data writes to latches
// [R14] busy flag set by hardware only
// [R15] control register resets to zero
// [R16] array is pages of 128 bytes
// [R17] busy held about 10 ms
// [R18] space code 11 launch does nothing
// [R19] core held idle while programming
// [R20] non-A after 5 drops the unlock
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "fseq_defines.svh"
module fseq_device #(
  parameter int PAGES = `FSEQ_PAGES,
  parameter int PAGE_BYTES = `FSEQ_PAGE_BYTES,
  parameter int PROG_CYCLES = `FSEQ_PROG_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  fseq_if.device link,
  output logic program_in_progress
);
  import fseq_pkg::*;
  localparam int IW = $clog2(PAGE_BYTES);
  localparam int PW = $clog2(PAGES);
  localparam int AW = IW + PW;
  localparam int HOLD = (PROG_CYCLES > 2 * PAGE_BYTES + 1) ?
                        PROG_CYCLES - 2 * PAGE_BYTES : 1;
  localparam logic [31:0] HOLD_LAST = 32'(HOLD - 1);
  localparam logic [IW-1:0] IDX_LAST = IW'(PAGE_BYTES - 1);

  fseq_byte_t array_mem [0:PAGES*PAGE_BYTES-1];
  fseq_byte_t xrow_mem [0:PAGE_BYTES-1];
  fseq_byte_t latch_mem [0:PAGE_BYTES-1];
  fseq_byte_t sec_r;
  logic [PAGE_BYTES-1:0] loaded_r;
  logic [PW-1:0] page_r;
  fseq_byte_t ctrl_r;
  logic armed_r;
  logic [1:0] target_r;
  fseq_state_e state_r;
  logic [IW-1:0] idx_r;
  logic [31:0] cnt_r;
  fseq_byte_t cr_rdata_r;
  logic cr_valid_r;
  logic [3:0] key;
  logic [1:0] space_wr;
  logic busy;
  logic wr_ok;
  logic launch;
  logic done;
  logic latch_we;
  logic [AW-1:0] mem_addr;
  fseq_byte_t mem_data;
  logic mem_we;

  assign key = link.fc_wdata[`FSEQ_KEY_HI:`FSEQ_KEY_LO];
  assign space_wr = link.fc_wdata[`FSEQ_SPACE_HI:`FSEQ_SPACE_LO];
  assign busy = ctrl_r[`FSEQ_BUSY_BIT];
  assign wr_ok = link.fc_we && !busy;
  // launch only on A right after 5, never with space code 11 [R12] [R18]
  assign launch = wr_ok && armed_r && (key == `FSEQ_KEY_GO) &&
                  (space_wr != `FSEQ_SP_RSVD);
  assign done = (state_r == fseq_write) && (idx_r == IDX_LAST);
  // data-space writes reach the latches only while mapped [R13] [R3]
  assign latch_we = link.xd_we && ctrl_r[`FSEQ_MAP_BIT] && !busy;
  assign mem_addr = {page_r, idx_r};
  assign mem_we = ((state_r == fseq_erase) || (state_r == fseq_write)) &&
                  loaded_r[idx_r];
  assign mem_data = (state_r == fseq_erase) ? `FSEQ_ERASED : latch_mem[idx_r];

  // control register; busy bit only moved by hardware [R15] [R14]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= `FSEQ_FC_RESET;
    end else if (launch) begin
      ctrl_r <= {link.fc_wdata[7:1], 1'b1};
    end else if (wr_ok) begin
      ctrl_r <= {link.fc_wdata[7:1], 1'b0};
    end else if (done) begin
      ctrl_r[`FSEQ_BUSY_BIT] <= 1'b0;
    end
  end

  // unlock: a 5 arms, anything else disarms [R12] [R20]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed_r <= 1'b0;
    end else if (wr_ok) begin
      armed_r <= (key == `FSEQ_KEY_ARM);
    end
  end

  // column latch storage, any count of bytes [R1] [R4] [R7]
  always_ff @(posedge hclk) begin
    if (latch_we) begin
      latch_mem[link.xd_addr[IW-1:0]] <= link.xd_wdata;
    end
  end

  // loaded marks and page of last load [R1] [R5]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      loaded_r <= '0;
      page_r <= '0;
    end else if (done) begin
      loaded_r <= '0;
    end else if (latch_we) begin
      loaded_r[link.xd_addr[IW-1:0]] <= 1'b1;
      page_r <= link.xd_addr[AW-1:IW];
    end
  end

  // sequence: erase walk, hold, program walk [R2] [R17] [R19]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= fseq_idle;
      idx_r <= '0;
      cnt_r <= '0;
      target_r <= `FSEQ_SP_USER;
    end else begin
      case (state_r)
        fseq_idle: begin
          idx_r <= '0;
          if (launch) begin
            state_r <= fseq_erase;
            target_r <= space_wr;
          end
        end
        fseq_erase: begin
          idx_r <= idx_r + 1'b1;
          cnt_r <= '0;
          if (idx_r == IDX_LAST) begin
            state_r <= fseq_hold;
          end
        end
        fseq_hold: begin
          cnt_r <= cnt_r + 32'h1;
          if (cnt_r == HOLD_LAST) begin
            state_r <= fseq_write;
          end
        end
        fseq_write: begin
          idx_r <= idx_r + 1'b1;
          if (done) begin
            state_r <= fseq_idle;
          end
        end
        default: begin
          state_r <= fseq_idle;
        end
      endcase
    end
  end

  // only loaded locations of the chosen space change [R2] [R16]
  always_ff @(posedge hclk) begin
    if (mem_we) begin
      case (target_r)
        `FSEQ_SP_USER: array_mem[mem_addr] <= mem_data;
        `FSEQ_SP_XROW: xrow_mem[idx_r] <= mem_data;
        default: begin
        end
      endcase
    end
  end

  // security byte: software reaches the upper nibble only [R8]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sec_r <= `FSEQ_SEC_DEFAULT;
    end else if (mem_we && target_r == `FSEQ_SP_SEC && idx_r == '0) begin
      sec_r[7:4] <= mem_data[7:4];
    end
  end

  // code-space reads through the mapped space [R9] [R10] [R11]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cr_valid_r <= 1'b0;
      cr_rdata_r <= '0;
    end else begin
      cr_valid_r <= link.cr_re && !busy;
      if (link.cr_re && !busy) begin
        case (ctrl_r[`FSEQ_SPACE_HI:`FSEQ_SPACE_LO])
          `FSEQ_SP_USER: cr_rdata_r <= array_mem[link.cr_addr[AW-1:0]];
          `FSEQ_SP_XROW: cr_rdata_r <=
            (link.cr_addr >= `FSEQ_XROW_BASE) ?
            xrow_mem[link.cr_addr[IW-1:0]] : `FSEQ_ERASED;
          `FSEQ_SP_SEC: cr_rdata_r <=
            (link.cr_addr == `FSEQ_SEC_ADDR) ? sec_r : `FSEQ_ERASED;
          default: cr_rdata_r <= `FSEQ_ERASED;
        endcase
      end
    end
  end

  assign link.fc_rdata = ctrl_r;
  assign link.cr_rdata = cr_rdata_r;
  assign link.cr_valid = cr_valid_r;
  assign link.core_hold = ctrl_r[`FSEQ_BUSY_BIT];
  assign program_in_progress = ctrl_r[`FSEQ_BUSY_BIT];
endmodule

// ### src/fseq_if.sv
// link between the core end and the flash sequencer end
// assumes both ends run on the same hclk
`timescale 1ns/1ps
interface fseq_if;
  logic fc_we;
  fseq_pkg::fseq_byte_t fc_wdata;
  fseq_pkg::fseq_byte_t fc_rdata;
  logic xd_we;
  fseq_pkg::fseq_addr_t xd_addr;
  fseq_pkg::fseq_byte_t xd_wdata;
  logic cr_re;
  fseq_pkg::fseq_addr_t cr_addr;
  fseq_pkg::fseq_byte_t cr_rdata;
  logic cr_valid;
  logic core_hold;
  modport device (
    input fc_we, fc_wdata, xd_we, xd_addr, xd_wdata, cr_re, cr_addr,
    output fc_rdata, cr_rdata, cr_valid, core_hold
  );
  modport core (
    output fc_we, fc_wdata, xd_we, xd_addr, xd_wdata, cr_re, cr_addr,
    input fc_rdata, cr_rdata, cr_valid, core_hold
  );
endinterface

// ### src/fseq_pkg.sv
// types shared by both ends of the flash program sequencer
// assumes nothing of its surroundings
package fseq_pkg;
  typedef logic [7:0] fseq_byte_t;
  typedef logic [15:0] fseq_addr_t;
  typedef enum logic [1:0] {
    fseq_idle = 2'b00,
    fseq_erase = 2'b01,
    fseq_hold = 2'b11,
    fseq_write = 2'b10
  } fseq_state_e;
endpackage

// ### tb/flash_program_sequencer_tb.sv
// bench: core end and sequencer end joined by the link, driven over AHB
// assumes a 4 ns hclk; programming time shortened to PROG cycles
`timescale 1ns/1ps
module flash_program_sequencer_tb;
  import fseq_pkg::*;
  localparam int PROG = 300;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = '0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic program_in_progress;
  logic rd_ph = 1'b0;
  logic any_ph = 1'b0;
  logic [31:0] rd;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  fseq_byte_t b[4];
  int n_errors = 0;
  int num_checks = 0;
  int seed = 45;
  fseq_if lk();
  always #2 hclk = ~hclk;
  fseq_device #(.PROG_CYCLES(PROG)) fseq_device_i (.hclk(hclk),
    .hresetn(hresetn), .link(lk.device),
    .program_in_progress(program_in_progress));
  fseq_core fseq_core_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .link(lk.core));
  fseq_checker #(.PROG(PROG)) fseq_checker_i (.hclk(hclk),
    .hresetn(hresetn), .fc_we(lk.fc_we), .fc_wdata(lk.fc_wdata),
    .fc_rdata(lk.fc_rdata), .cr_re(lk.cr_re), .cr_valid(lk.cr_valid),
    .core_hold(lk.core_hold), .program_in_progress(program_in_progress));
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check_word(input logic [31:0] e, g, m);
    num_checks++;
    if ((g & m) !== (e & m)) begin
      n_errors++;
      $display("ERROR hrdata expected %h seen %h", e & m, g & m);
    end
  endtask
  task automatic check_resp(input logic g);
    num_checks++;
    if (g !== 1'b0) begin
      n_errors++;
      $display("ERROR hresp expected 0 seen %b", g);
    end
  endtask
  task automatic wait_rdy();
    int n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (hreadyout !== 1'b1) begin
      n_errors++;
      final_report();
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d, e, m);
    if (!w) begin
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    if (w) repeat (3) @(posedge hclk);
  endtask
  task automatic ctl(input fseq_byte_t v);
    bus(1'b1, 32'h0, {24'h0, v}, 32'h0, 32'h0);
  endtask
  task automatic ld(input fseq_addr_t a, input fseq_byte_t v);
    bus(1'b1, 32'h4, {8'h0, v, a}, 32'h0, 32'h0);
  endtask
  task automatic cread(input fseq_addr_t a, input fseq_byte_t e, m);
    bus(1'b1, 32'h8, {16'h0, a}, 32'h0, 32'h0);
    bus(1'b0, 32'hc, 32'h0, {24'h0, e}, {24'h0, m});
  endtask
  task automatic stat(input fseq_byte_t e, m);
    bus(1'b0, 32'h0, 32'h0, {24'h0, e}, {24'h0, m});
  endtask
  task automatic go(input logic [3:0] lo, input bit done);
    int n = 0;
    ctl({4'h5, lo});
    ctl({4'ha, lo});
    if (done) begin
      do begin
        stat(8'h0, 8'h0);
        n++;
      end while (rd[0] !== 1'b0 && n < 400);
      if (rd[0] !== 1'b0) begin
        n_errors++;
        final_report();
      end
    end
  endtask
  always @(posedge hclk) begin
    if (any_ph) check_resp(hresp);
    if (rd_ph && hreadyout === 1'b1 && exp_q.size() > 0) begin
      if (msk_q[0] != 32'h0) check_word(exp_q[0], hrdata, msk_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
    rd_ph <= hsel && htrans[1] && !hwrite && hreadyout;
    any_ph <= hsel && htrans[1] && hreadyout;
  end
  initial begin
    #100000;
    n_errors++;
    final_report();
  end
  initial begin
    foreach (b[i]) b[i] = 8'($random(seed));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    stat(8'h00, 8'hff);
    bus(1'b0, 32'h10, 32'h0, 32'h0, 32'hffffffff);
    ctl(8'h08);
    ld(16'h0100, b[0]);
    ld(16'h7f81, b[1]);
    ld(16'h7fff, b[2]);
    ctl(8'h50);
    stat(8'h50, 8'hff);
    ctl(8'ha0);
    stat(8'ha1, 8'hff);
    ctl(8'h00);
    stat(8'ha1, 8'hff);
    bus(1'b1, 32'h8, 32'h7f80, 32'h0, 32'h0);
    bus(1'b0, 32'hc, 32'h0, 32'h0003a100, 32'h0003ff00);
    go(4'h0, 1'b1);
    bus(1'b0, 32'hc, 32'h0, 32'h0, 32'h00030000);
    ctl(8'h08);
    ld(16'h7f81, b[3]);
    go(4'h0, 1'b1);
    ctl(8'h00);
    cread(16'h7f80, b[0], 8'hff);
    cread(16'h7f81, b[3], 8'hff);
    cread(16'h7fff, b[2], 8'hff);
    ctl(8'h50);
    ctl(8'h20);
    ctl(8'ha0);
    stat(8'h00, 8'h01);
    go(4'h6, 1'b0);
    stat(8'h00, 8'h01);
    ctl(8'h0a);
    ld(16'hff85, b[1]);
    go(4'h2, 1'b1);
    ctl(8'h02);
    cread(16'hff85, b[1], 8'hff);
    cread(16'h0005, 8'hff, 8'hff);
    ctl(8'h0c);
    ld(16'h0000, b[2]);
    go(4'h4, 1'b1);
    ctl(8'h04);
    cread(16'h0000, {b[2][7:4], 4'hf}, 8'hff);
    ctl(8'h06);
    cread(16'h7f80, 8'hff, 8'hff);
    go(4'h0, 1'b0);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    stat(8'h00, 8'hff);
    repeat (3) @(posedge hclk);
    final_report();
  end
endmodule

// ### tb/fseq_checker.sv
// link checks between the core end and the sequencer end
// assumes one clock hclk and asynchronous active-low hresetn
`timescale 1ns/1ps
module fseq_checker #(
  parameter int PROG = 300
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic fc_we,
  input wire fseq_pkg::fseq_byte_t fc_wdata,
  input wire fseq_pkg::fseq_byte_t fc_rdata,
  input wire logic cr_re,
  input wire logic cr_valid,
  input wire logic core_hold,
  input wire logic program_in_progress
);
  import fseq_pkg::*;
  logic armed_r;
  logic [31:0] cnt_r;
  logic busy;
  logic go;
  assign busy = fc_rdata[0];
  assign go = fc_we && !busy && armed_r && fc_wdata[7:4] == 4'ha &&
    fc_wdata[2:1] != 2'h3;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) armed_r <= 1'b0;
    else if (fc_we && !busy) armed_r <= fc_wdata[7:4] == 4'h5;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cnt_r <= '0;
    else cnt_r <= busy ? cnt_r + 32'h1 : '0;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  reset_zero_a: assert property (!$past(hresetn) |->
    fc_rdata == 8'h00) else $error("control register not zero after reset");
  busy_mirror_a: assert property (core_hold == busy &&
    program_in_progress == busy) else $error("hold or busy out of step");
  launch_go_a: assert property (go |=> busy)
    else $error("key sequence did not start programming");
  launch_none_a: assert property (fc_we && !busy && !go |=> !busy)
    else $error("programming started without key sequence");
  ctrl_write_a: assert property (fc_we && !busy |=>
    fc_rdata[7:1] == $past(fc_wdata[7:1])) else $error("control not written");
  busy_ignore_a: assert property (fc_we && busy |=>
    fc_rdata[7:1] == $past(fc_rdata[7:1]))
    else $error("write taken while busy");
  prog_len_a: assert property ($fell(busy) |-> cnt_r >= PROG - 8 &&
    cnt_r <= PROG + 8) else $error("busy length wrong");
  prog_bound_a: assert property (busy |-> cnt_r <= PROG + 8)
    else $error("busy held too long");
  read_answer_a: assert property (cr_re && !core_hold |=> cr_valid)
    else $error("code read not answered");
  read_held_a: assert property (cr_re && core_hold |=> !cr_valid)
    else $error("code read answered while busy");
  read_quiet_a: assert property (!cr_re |=> !cr_valid)
    else $error("code read answer without request");
  hold_launch_a: assert property ($rose(core_hold) |-> $past(go))
    else $error("core held without a launch");
endmodule
